// ### hdl/divp_top.sv
/*
  Interrupt vector and priority resolver for the core sequencer.
  Latches source events, picks the highest priority pending trap and
  presents its trap number and vector until the sequencer takes it.
  Assumes sources give one-cycle event pulses synchronous to clk and
  the sequencer answers with a one-cycle take strobe.
*/
// Function
// - Reset is trap 0, priority 1, vector 0; NMI trap 1, vector 4
// - Vector equals four times trap; ext user irq zero is trap 16
// - Ext user irqs one, two are traps 17, 18; timer zero trap 19
// - Ext user irq three is trap 24; host port irq is trap 25
// - Serial port zero receive and transmit are traps 20 and 21
// - First variant: trap 22 belongs only to DMA channel zero
// - First variant: trap 23 from timer one, or DMA one if selected
// - Traps 26, 27 from serial port one, or DMA two and three
// - Second variant: traps 22, 23 from serial port two or DMA 0, 1
// - DMA channel four completion is trap 28, vector 70
// - DMA five is trap 29; vectors 78 to 7F never produced
// - Lowest priority number wins; traps 2 to 15 have no hardware
`timescale 1ns/1ns
`include "divp_consts.svh"
module divp_top
#(
  parameter divp_pkg::divp_variant_t VARIANT =
    divp_pkg::DIVP_VARIANT_FIRST           // Interrupt map in use
)
(
  input  wire logic                clk,                     // Core clock
  input  wire logic                rst_b,                   // Sync reset
  input  wire logic                sw_reset_req,            // Soft reset
  input  wire logic                nmi_req,                 // NMI event
  input  wire logic                ext_user_irq_zero,       // Ext irq 0
  input  wire logic                ext_user_irq_one,        // Ext irq 1
  input  wire logic                ext_user_irq_two,        // Ext irq 2
  input  wire logic                ext_user_irq_three,      // Ext irq 3
  input  wire logic                timer_zero_irq,          // Timer 0
  input  wire logic                timer_one_irq,           // Timer 1
  input  wire logic                serial_port_zero_rx_irq, // Port 0 rx
  input  wire logic                serial_port_zero_tx_irq, // Port 0 tx
  input  wire logic                serial_port_one_rx_irq,  // Port 1 rx
  input  wire logic                serial_port_one_tx_irq,  // Port 1 tx
  input  wire logic                serial_port_two_rx_irq,  // Port 2 rx
  input  wire logic                serial_port_two_tx_irq,  // Port 2 tx
  input  wire logic                host_port_irq,           // Host port
  input  wire logic                dma_zero_irq,            // DMA ch 0
  input  wire logic                dma_one_irq,             // DMA ch 1
  input  wire logic                dma_two_irq,             // DMA ch 2
  input  wire logic                dma_three_irq,           // DMA ch 3
  input  wire logic                dma_four_irq,            // DMA ch 4
  input  wire logic                dma_five_irq,            // DMA ch 5
  input  wire divp_pkg::divp_sel_t dma_alt_sel,             // Slot selects
  input  wire logic                trap_take,               // Seq takes
  output logic                     trap_valid,              // Trap shown
  output divp_pkg::divp_trap_t     trap_number,             // Winner trap
  output divp_pkg::divp_vec_t      trap_vector              // Winner vec
);
  import divp_pkg::*;

  divp_sel_t  sel_ff;
  divp_sel_t  nxt_sel;
  divp_pend_t pend_ff;
  divp_pend_t nxt_pend;
  divp_pend_t set_vec;
  divp_pend_t clr_vec;
  logic       valid_ff;
  logic       nxt_valid;
  divp_trap_t trap_ff;
  divp_trap_t nxt_trap;
  divp_vec_t  vec_ff;
  divp_vec_t  nxt_vec;

  divp_slot_if slot_if [4] ();

  // Selects are registered so a source swap takes effect cleanly
  always_comb
  begin
    nxt_sel = dma_alt_sel;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sel_ff <= `DIVP_SEL_RST;
    end
    else
    begin
      sel_ff <= nxt_sel;
    end
  end

  // Slot 22: first variant has no alternate, DMA zero only
  always_comb
  begin
    if (VARIANT == DIVP_VARIANT_SECOND)
    begin
      slot_if[`DIVP_SLOT_IDX22].dflt_irq = serial_port_two_rx_irq;
      slot_if[`DIVP_SLOT_IDX22].alt_sel  = sel_ff[`DIVP_SLOT_IDX22];
    end
    else
    begin
      slot_if[`DIVP_SLOT_IDX22].dflt_irq = dma_zero_irq;
      slot_if[`DIVP_SLOT_IDX22].alt_sel  = 1'b0;
    end
    slot_if[`DIVP_SLOT_IDX22].alt_irq = dma_zero_irq;
  end

  // Slot 23: default source depends on the variant
  always_comb
  begin
    if (VARIANT == DIVP_VARIANT_SECOND)
    begin
      slot_if[`DIVP_SLOT_IDX23].dflt_irq = serial_port_two_tx_irq;
    end
    else
    begin
      slot_if[`DIVP_SLOT_IDX23].dflt_irq = timer_one_irq;
    end
    slot_if[`DIVP_SLOT_IDX23].alt_irq = dma_one_irq;
    slot_if[`DIVP_SLOT_IDX23].alt_sel = sel_ff[`DIVP_SLOT_IDX23];
  end

  // Slots 26 and 27 are the same in both variants
  always_comb
  begin
    slot_if[`DIVP_SLOT_IDX26].dflt_irq = serial_port_one_rx_irq;
    slot_if[`DIVP_SLOT_IDX26].alt_irq  = dma_two_irq;
    slot_if[`DIVP_SLOT_IDX26].alt_sel  = sel_ff[`DIVP_SLOT_IDX26];
    slot_if[`DIVP_SLOT_IDX27].dflt_irq = serial_port_one_tx_irq;
    slot_if[`DIVP_SLOT_IDX27].alt_irq  = dma_three_irq;
    slot_if[`DIVP_SLOT_IDX27].alt_sel  = sel_ff[`DIVP_SLOT_IDX27];
  end

  for (genvar gi = 0; gi < 4; gi++)
  begin : g_slot
    divp_slot_mux u_mux
    (
      .bus (slot_if[gi])
    );
  end

  // Source events onto their trap positions
  always_comb
  begin
    set_vec                       = '0;
    set_vec[`DIVP_TRAP_RESET]     = sw_reset_req;
    set_vec[`DIVP_TRAP_NMI]       = nmi_req;
    set_vec[`DIVP_TRAP_EXT0]      = ext_user_irq_zero;
    set_vec[`DIVP_TRAP_EXT1]      = ext_user_irq_one;
    set_vec[`DIVP_TRAP_EXT2]      = ext_user_irq_two;
    set_vec[`DIVP_TRAP_TIMER0]    = timer_zero_irq;
    set_vec[`DIVP_TRAP_SP0_RX]    = serial_port_zero_rx_irq;
    set_vec[`DIVP_TRAP_SP0_TX]    = serial_port_zero_tx_irq;
    set_vec[`DIVP_TRAP_SLOT22]    = slot_if[`DIVP_SLOT_IDX22].slot_irq;
    set_vec[`DIVP_TRAP_SLOT23]    = slot_if[`DIVP_SLOT_IDX23].slot_irq;
    set_vec[`DIVP_TRAP_EXT3]      = ext_user_irq_three;
    set_vec[`DIVP_TRAP_HOST]      = host_port_irq;
    set_vec[`DIVP_TRAP_SLOT26]    = slot_if[`DIVP_SLOT_IDX26].slot_irq;
    set_vec[`DIVP_TRAP_SLOT27]    = slot_if[`DIVP_SLOT_IDX27].slot_irq;
    set_vec[`DIVP_TRAP_DMA4]      = dma_four_irq;
    set_vec[`DIVP_TRAP_DMA5]      = dma_five_irq;
  end

  // Taken trap is cleared; a new event in the same cycle wins
  always_comb
  begin
    clr_vec = '0;
    if (valid_ff && trap_take)
    begin
      clr_vec[trap_ff] = 1'b1;
    end
    nxt_pend = ((pend_ff & ~clr_vec) | set_vec) & `DIVP_HW_MASK;
  end

  // Priority rises as trap number falls, so lowest set bit wins
  always_comb
  begin
    nxt_trap  = trap_ff;
    nxt_valid = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      if (nxt_pend[i])
      begin
        nxt_trap  = divp_trap_t'(i);
        nxt_valid = 1'b1;
      end
    end
    if (!nxt_valid)
    begin
      nxt_trap = `DIVP_TRAP_RST;
    end
    nxt_vec = divp_vec_t'({2'b00, nxt_trap} << `DIVP_VEC_SHIFT);
  end

  // Reset leaves the reset trap pending for the sequencer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pend_ff  <= `DIVP_PEND_RST;
      valid_ff <= 1'b0;
      trap_ff  <= `DIVP_TRAP_RST;
      vec_ff   <= `DIVP_VEC_RST;
    end
    else
    begin
      pend_ff  <= nxt_pend;
      valid_ff <= nxt_valid;
      trap_ff  <= nxt_trap;
      vec_ff   <= nxt_vec;
    end
  end

  assign trap_valid  = valid_ff;
  assign trap_number = trap_ff;
  assign trap_vector = vec_ff;
endmodule

// ### hdl/divp_consts.svh
/*
  Constants for the interrupt vector and priority resolver: trap
  numbers of every hardware source, vector forming, reset values.
  Assumes inclusion by the package and by the design modules.
*/
`ifndef DIVP_CONSTS_SVH
`define DIVP_CONSTS_SVH

// Trap numbers of the hardware sources
`define DIVP_TRAP_RESET     5'h00
`define DIVP_TRAP_NMI       5'h01
`define DIVP_TRAP_EXT0      5'h10
`define DIVP_TRAP_EXT1      5'h11
`define DIVP_TRAP_EXT2      5'h12
`define DIVP_TRAP_TIMER0    5'h13
`define DIVP_TRAP_SP0_RX    5'h14
`define DIVP_TRAP_SP0_TX    5'h15
`define DIVP_TRAP_SLOT22    5'h16
`define DIVP_TRAP_SLOT23    5'h17
`define DIVP_TRAP_EXT3      5'h18
`define DIVP_TRAP_HOST      5'h19
`define DIVP_TRAP_SLOT26    5'h1A
`define DIVP_TRAP_SLOT27    5'h1B
`define DIVP_TRAP_DMA4      5'h1C
`define DIVP_TRAP_DMA5      5'h1D

// Vector location is trap number shifted left by this amount
`define DIVP_VEC_SHIFT      2

// Traps that hardware may raise; 2..15 and 30..31 never set
`define DIVP_HW_MASK        32'h3FFF0003

// Pending set after reset release: the reset trap itself
`define DIVP_PEND_RST       32'h00000001
`define DIVP_SEL_RST        4'h0
`define DIVP_TRAP_RST       5'h00
`define DIVP_VEC_RST        7'h00

// Index of each shared slot within the select group
`define DIVP_SLOT_IDX22     0
`define DIVP_SLOT_IDX23     1
`define DIVP_SLOT_IDX26     2
`define DIVP_SLOT_IDX27     3

`endif

// ### hdl/divp_pkg.sv
/*
  Types for the interrupt vector and priority resolver.
  Assumes divp_consts.svh on the include path.
*/
package divp_pkg;
  typedef logic [4:0]  divp_trap_t;
  typedef logic [6:0]  divp_vec_t;
  typedef logic [31:0] divp_pend_t;
  typedef logic [3:0]  divp_sel_t;
  typedef enum logic
  {
    DIVP_VARIANT_FIRST,
    DIVP_VARIANT_SECOND
  } divp_variant_t;
endpackage

// ### hdl/divp_slot_if.sv
/*
  Carrier for one shared interrupt slot: default source, alternate
  DMA source, select, and the routed request.
  Assumes one instance per shared slot inside the resolver.
*/
`timescale 1ns/1ns
interface divp_slot_if;
  logic dflt_irq;
  logic alt_irq;
  logic alt_sel;
  logic slot_irq;
  modport mux
  (
    input  dflt_irq,
    input  alt_irq,
    input  alt_sel,
    output slot_irq
  );
  modport top
  (
    output dflt_irq,
    output alt_irq,
    output alt_sel,
    input  slot_irq
  );
endinterface

// ### hdl/divp_slot_mux.sv
/*
  Source selector for one shared interrupt slot.
  Assumes a registered select from the resolver.
*/
`timescale 1ns/1ns
module divp_slot_mux
(
  divp_slot_if.mux bus  // One shared slot
);
  always_comb
  begin
    bus.slot_irq = bus.alt_sel ? bus.alt_irq : bus.dflt_irq;
  end
endmodule

// ### verification/divp_properties.sv
/* Assertions on the resolver top ports.
   Assumes binding to divp_top, reset sync active low. */
`timescale 1ns/1ns
module divp_checker
(
  input wire logic                 clk,               // Clock
  input wire logic                 rst_b,             // Reset
  input wire logic                 nmi_req,           // NMI
  input wire logic                 ext_user_irq_zero, // Ext 0
  input wire logic                 dma_four_irq,      // DMA 4
  input wire logic                 dma_five_irq,      // DMA 5
  input wire logic                 trap_take,         // Take
  input wire logic                 trap_valid,        // Shown
  input wire divp_pkg::divp_trap_t trap_number,       // Trap
  input wire divp_pkg::divp_vec_t  trap_vector        // Vector
);
  import divp_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_vec_shift: assert property (
    trap_vector == {trap_number, 2'b00}) else $error("vector mismatch");
  a_no_soft: assert property (
    trap_valid |-> !(trap_number inside {[5'h02:5'h0F], 5'h1E, 5'h1F}))
    else $error("software-only trap shown");
  a_reset_first: assert property (
    $rose(rst_b) |=> trap_valid && trap_number == 5'h00)
    else $error("reset trap not shown");
  a_nmi_next: assert property (
    nmi_req |=> trap_valid && trap_number <= 5'h01) else $error("nmi late");
  a_ext_zero: assert property (
    ext_user_irq_zero |=> trap_valid && trap_number <= 5'h10)
    else $error("ext 0 late");
  a_dma_four: assert property (
    dma_four_irq |=> trap_valid && trap_number <= 5'h1C)
    else $error("dma 4 late");
  a_dma_five: assert property (
    dma_five_irq |=> trap_valid && trap_number <= 5'h1D)
    else $error("dma 5 late");
  a_hold_best: assert property (
    trap_valid && !trap_take |=>
      trap_valid && trap_number <= $past(trap_number))
    else $error("shown trap dropped or worsened");
endmodule
bind divp_top divp_checker divp_checker_i
(
  .clk, .rst_b, .nmi_req, .ext_user_irq_zero, .dma_four_irq,
  .dma_five_irq, .trap_take, .trap_valid, .trap_number, .trap_vector
);

// ### verification/divp_seq_model.sv
/* Sequencer stand-in that takes shown traps.
   Assumes mode 0 prompt, 1 slow, 2 stalled. */
`timescale 1ns/1ns
module divp_seq_model
(
  input  wire logic       clk,        // Clock
  input  wire logic       rst_b,      // Reset
  input  wire logic       trap_valid, // Shown
  input  wire logic [1:0] mode,       // Pace
  output logic            trap_take   // Take
);
  // Prompt mode strobes while idle too; design must ignore that
  initial trap_take = 1'b0;
  always @(negedge clk)
    trap_take <= rst_b && (mode == 2'h0 ||
      (mode == 2'h1 && trap_valid && $urandom_range(3) == 0));
endmodule

// ### verification/dsp_interrupt_vector_priority_tb.sv
/* Self-checking bench for divp_top, both interrupt maps side by side.
   Assumes a pending-set reference model and a sequencer stand-in. */
`timescale 1ns/1ns
module dsp_interrupt_vector_priority_tb;
  import divp_pkg::*;
  logic        clk, rst_b, trap_take, trap_valid, xv, valid2, xv2;
  logic [31:0] ev;
  logic [1:0]  mode;
  divp_sel_t   sel, sel_q;
  divp_trap_t  trap_number, xn, num2, xn2;
  divp_vec_t   trap_vector, vec2;
  divp_pend_t  pend, p, pend2, p2;
  int          errors, checked, seed;
  always #20 clk = ~clk;
  // Event bit k feeds trap k; DMA alternates sit in unused bits 3..5
  divp_top divp_top_i
  (
    .clk(clk), .rst_b(rst_b), .sw_reset_req(ev[0]), .nmi_req(ev[1]),
    .ext_user_irq_zero(ev[16]), .ext_user_irq_one(ev[17]),
    .ext_user_irq_two(ev[18]), .ext_user_irq_three(ev[24]),
    .timer_zero_irq(ev[19]), .timer_one_irq(ev[23]),
    .serial_port_zero_rx_irq(ev[20]), .serial_port_zero_tx_irq(ev[21]),
    .serial_port_one_rx_irq(ev[26]), .serial_port_one_tx_irq(ev[27]),
    .serial_port_two_rx_irq(ev[6]), .serial_port_two_tx_irq(ev[7]),
    .host_port_irq(ev[25]), .dma_zero_irq(ev[22]), .dma_one_irq(ev[3]),
    .dma_two_irq(ev[4]), .dma_three_irq(ev[5]), .dma_four_irq(ev[28]),
    .dma_five_irq(ev[29]), .dma_alt_sel(sel), .trap_take(trap_take),
    .trap_valid(trap_valid), .trap_number(trap_number),
    .trap_vector(trap_vector)
  );
  // Second map on the same events; bits 6, 7 feed its serial port two
  divp_top #(.VARIANT(DIVP_VARIANT_SECOND)) divp_top_i2
  (
    .clk(clk), .rst_b(rst_b), .sw_reset_req(ev[0]), .nmi_req(ev[1]),
    .ext_user_irq_zero(ev[16]), .ext_user_irq_one(ev[17]),
    .ext_user_irq_two(ev[18]), .ext_user_irq_three(ev[24]),
    .timer_zero_irq(ev[19]), .timer_one_irq(ev[23]),
    .serial_port_zero_rx_irq(ev[20]), .serial_port_zero_tx_irq(ev[21]),
    .serial_port_one_rx_irq(ev[26]), .serial_port_one_tx_irq(ev[27]),
    .serial_port_two_rx_irq(ev[6]), .serial_port_two_tx_irq(ev[7]),
    .host_port_irq(ev[25]), .dma_zero_irq(ev[22]), .dma_one_irq(ev[3]),
    .dma_two_irq(ev[4]), .dma_three_irq(ev[5]), .dma_four_irq(ev[28]),
    .dma_five_irq(ev[29]), .dma_alt_sel(sel), .trap_take(trap_take),
    .trap_valid(valid2), .trap_number(num2), .trap_vector(vec2)
  );
  divp_seq_model divp_seq_model_i
  (
    .clk(clk), .rst_b(rst_b), .trap_valid(trap_valid), .mode(mode),
    .trap_take(trap_take)
  );
  // Next pending set from the rules; second picks the second map
  function automatic divp_pend_t nxt_p(divp_pend_t q, logic v,
    divp_trap_t n, logic second);
    divp_pend_t r;
    r = q;
    if (v && trap_take)
      r[n] = 1'b0;
    r = r | (ev & 32'h333F0003);
    if (second)
    begin
      r[22] = r[22] | (sel_q[0] ? ev[22] : ev[6]);
      r[23] = r[23] | (sel_q[1] ? ev[3] : ev[7]);
    end
    else
    begin
      r[22] = r[22] | ev[22];
      r[23] = r[23] | (sel_q[1] ? ev[3] : ev[23]);
    end
    r[26] = r[26] | (sel_q[2] ? ev[4] : ev[26]);
    r[27] = r[27] | (sel_q[3] ? ev[5] : ev[27]);
    if (!rst_b)
      r = 32'h00000001;
    return r;
  endfunction
  // Lowest pending trap number wins
  function automatic divp_trap_t best(divp_pend_t q);
    best = 5'h00;
    for (int i = 29; i >= 0; i--)
      if (q[i])
        best = 5'(i);
  endfunction
  always @(posedge clk)
  begin
    p = nxt_p(pend, xv, xn, 1'b0);
    p2 = nxt_p(pend2, xv2, xn2, 1'b1);
    pend <= p;
    pend2 <= p2;
    xv <= rst_b && p != 32'h0;
    xv2 <= rst_b && p2 != 32'h0;
    xn <= best(p);
    xn2 <= best(p2);
    sel_q <= rst_b ? sel : 4'h0;
  end
  task automatic results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(logic [31:0] e);
    @(negedge clk);
    checked++;
    if ({trap_valid,trap_number,trap_vector} !== {xv,xn,xn,2'b00})
    begin
      errors++;
      $display("ERROR valid_trap_vector exp %h got %h", {xv, xn, xn, 2'b00},
        {trap_valid, trap_number, trap_vector});
    end
    checked++;
    if ({valid2,num2,vec2} !== {xv2,xn2,xn2,2'b00})
    begin
      errors++;
      $display("ERROR second_map exp %h got %h", {xv2, xn2, xn2, 2'b00},
        {valid2, num2, vec2});
    end
    ev = e;
  endtask
  initial
  begin
    #(40 * 20000);
    errors++;
    results();
  end
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    ev = 32'h0;
    sel = 4'h0;
    mode = 2'h0;
    errors = 0;
    checked = 0;
    seed = $urandom(32'h82137785);
    repeat (16) @(negedge clk);
    cyc(32'h0);
    rst_b <= 1'b1;
    repeat (3) cyc(32'h0);
    // Every source alone, default routes then DMA routes
    for (int s = 0; s < 2; s++)
    begin
      sel = s ? 4'hF : 4'h0;
      for (int i = 0; i < 32; i++)
      begin
        cyc(32'h1 << i);
        repeat (2) cyc(32'h0);
      end
    end
    mode <= 2'h2;
    cyc(32'hFFFFFFFF);
    mode <= 2'h0;
    repeat (20) cyc(32'h0);
    repeat (3000)
    begin
      sel = 4'($urandom);
      mode <= 2'($urandom_range(2));
      cyc($urandom & $urandom & $urandom);
    end
    // Reset in mid-run with traps still pending
    mode <= 2'h2;
    cyc(32'h0A5A5A5A);
    cyc(32'h0);
    rst_b <= 1'b0;
    repeat (2) cyc(32'h0);
    rst_b <= 1'b1;
    mode <= 2'h0;
    repeat (5) cyc(32'h0);
    results();
  end
endmodule
